// file: core/bcb_pkg.sv
// shared constants and types for the backplane cycle bus engine
package bcb_pkg;

	// ==========================================================
	// timing
	localparam int CLOCK_MHZ = 50;
	localparam int READY_WINDOW_NS = 500;
	// longest time: round down
	localparam int READY_WINDOW_CYC = (READY_WINDOW_NS * CLOCK_MHZ) / 1000;
	localparam int RESTART_MIN_NS = 3;
	// least time: round up, never below one cycle
	localparam int RESTART_MIN_CYC =
		((RESTART_MIN_NS * CLOCK_MHZ + 999) / 1000) < 1 ? 1 :
		((RESTART_MIN_NS * CLOCK_MHZ + 999) / 1000);
	localparam int PHASE_DIV_DEFAULT = 10;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_WDATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_RDATA = 8'h10;

	// ==========================================================
	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_HALT_BIT = 1;
	localparam int CTRL_ACK_BIT = 2;
	localparam int CTRL_TYPE_LSB = 4;
	localparam int ADDR_LOW_LSB = 0;
	localparam int ADDR_PAGE_LSB = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WAIT_BIT = 1;
	localparam int ST_HALT_BIT = 2;
	localparam int ST_L0_BIT = 3;
	localparam int ST_SUB_BIT = 4;
	localparam int ST_HOLD_BIT = 5;
	localparam int ST_INT_LSB = 8;

	// ==========================================================
	// reset values and cycle-type codes
	localparam logic [1:0] TYPE_RESET = 2'h0;
	localparam logic [13:0] ADDR_RESET = 14'h0000;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] CYC_FETCH = 2'h0;
	localparam logic [1:0] CYC_READ = 2'h1;
	localparam logic [1:0] CYC_IO = 2'h2;
	localparam logic [1:0] CYC_WRITE = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE, ST_T1, ST_T2, ST_WIN, ST_WAIT, ST_T3
	} bcb_state_t;

endpackage

// file: core/bcb_phase_gen.sv
// phase-two clock divider with sync and state tick
`timescale 1ns/1ps
module bcb_phase_gen
	import bcb_pkg::*;
#(
	parameter int DIV = PHASE_DIV_DEFAULT
)
(
	input wire logic clock, // system clock
	input wire logic reset, // synchronous, active high
	output logic tick, // one-cycle pulse at end of each phase period
	output logic phase2Clock, // distributed phase-two time base
	output logic sync_n // low in first half of each period
);

	// ==========================================================
	// divider
	logic [15:0] count;
	logic [15:0] next_count;
	logic next_phase2Clock;
	logic next_sync_n;

	// the half point keeps the phase-two output near square
	always_comb
	begin
		next_count = (count == 16'(DIV - 1)) ? 16'h0000 : count + 16'h0001;
		next_phase2Clock = (next_count >= 16'(DIV / 2));
		next_sync_n = (next_count >= 16'(DIV / 2));
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			count <= 16'h0000;
			phase2Clock <= 1'b0;
			sync_n <= 1'b1;
		end
		else
		begin
			count <= next_count;
			phase2Clock <= next_phase2Clock;
			sync_n <= next_sync_n;
		end
	end

	assign tick = (count == 16'(DIV - 1));

endmodule

// file: core/bcb_level_zero.sv
// restart line filter and level-zero request flag
`timescale 1ns/1ps
module bcb_level_zero
	import bcb_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic restart_n, // restart line, low restarts
	input wire logic ack, // level-zero interrupt acknowledged
	output logic level_zero_request_n, // flag, low while pending
	output logic level_zero_request_edge // pulse when request raised
);

	// ==========================================================
	// restart qualifier and flag
	logic [3:0] lowCount;
	logic [3:0] next_lowCount;
	logic pending;
	logic next_pending;
	logic next_edge;
	logic hit;

	// a fresh restart beats a concurrent acknowledge
	always_comb
	begin
		hit = 1'b0;
		next_lowCount = 4'h0;
		if (!restart_n)
		begin
			next_lowCount = (lowCount == 4'hf) ? lowCount : lowCount + 4'h1;
			hit = (next_lowCount == 4'(RESTART_MIN_CYC));
		end
		next_pending = pending;
		if (hit)
			next_pending = 1'b1;
		else if (ack)
			next_pending = 1'b0;
		next_edge = next_pending && !pending;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			lowCount <= 4'h0;
			pending <= 1'b0;
			level_zero_request_edge <= 1'b0;
		end
		else
		begin
			lowCount <= next_lowCount;
			pending <= next_pending;
			level_zero_request_edge <= next_edge;
		end
	end

	assign level_zero_request_n = !pending;

endmodule

// file: core/bcb_bus_engine.sv
// processor-side backplane cycle engine with apb control
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module bcb_bus_engine
	import bcb_pkg::*;
#(
	parameter int PHASE_DIV = PHASE_DIV_DEFAULT,
	parameter int WIN_CYC = READY_WINDOW_CYC
)
(
	input wire logic clock, // 50 MHz system clock
	input wire logic reset, // synchronous, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	output logic phase2Clock, // phase-two time base
	output logic sync_n, // basic period marker
	output logic high_address_phase_n, // T2 timing
	output logic third_phase_n, // T3 timing
	output logic extThirdPhase_n, // extended third phase
	output logic cycle_type_bit0_n, // cycle type bit 0, negative
	output logic cycle_type_bit1, // cycle type bit 1, positive
	output logic [7:0] low_address_lines_n, // low address or io data
	output logic [5:0] page_address_lines_n, // page or instruction bits
	input wire logic [7:0] data_lines_n_in, // data lines as seen
	output logic [7:0] data_lines_n_out, // data lines driven value
	output logic data_lines_n_oe, // high while driving data lines
	input wire logic ready_n, // wait-request line, high asks wait
	input wire logic steppingHold_n, // console hold, low forces wait
	input wire logic restart_n, // restart line
	input wire logic substitute_n, // substitution override
	input wire logic [7:1] interrupt_request_lines_n, // levels 7..1
	input wire logic master_reset, // master reset, active high
	output logic level_zero_request_n, // level-zero flag
	output logic waitIndicator_n, // low in WAIT from wait-request
	output logic haltedIndicator_n // low while halted
);

	// ==========================================================
	// submodules
	logic tick;
	logic l0Edge;
	logic ackWrite;

	bcb_phase_gen #(
		.DIV(PHASE_DIV)
	) phaseGen (
		.clock(clock),
		.reset(reset),
		.tick(tick),
		.phase2Clock(phase2Clock),
		.sync_n(sync_n)
	);

	bcb_level_zero levelZero (
		.clock(clock),
		.reset(reset),
		.restart_n(restart_n),
		.ack(ackWrite),
		.level_zero_request_n(level_zero_request_n),
		.level_zero_request_edge(l0Edge)
	);

	// ==========================================================
	// apb decode
	logic wrAccess;
	logic rdSetup;
	logic mapped;
	logic wrCtrl;

	// writes land only in the completing access cycle
	always_comb
	begin
		mapped = (paddr <= OFS_RDATA) && (paddr[1:0] == 2'h0);
		wrAccess = psel && penable && pwrite && mapped;
		rdSetup = psel && !penable;
		wrCtrl = wrAccess && (paddr == OFS_CTRL);
		ackWrite = wrCtrl && pwdata[CTRL_ACK_BIT];
	end

	// zero wait states: every access finishes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ==========================================================
	// control registers
	logic [1:0] cycType;
	logic [13:0] addrReg;
	logic [7:0] wdataReg;
	logic [7:0] rdataReg;
	logic pending;
	logic halted;
	bcb_state_t state;
	logic [1:0] next_cycType;
	logic [13:0] next_addrReg;
	logic [7:0] next_wdataReg;
	logic [7:0] next_rdataReg;
	logic next_pending;
	logic next_halted;
	logic wake;
	logic anyInt;
	logic cycleDone;

	// setup is frozen while a cycle runs so the bus never shifts mid-cycle
	always_comb
	begin
		anyInt = |(~interrupt_request_lines_n);
		wake = master_reset || anyInt || l0Edge;
		cycleDone = (state == ST_T3) && tick;
		next_cycType = cycType;
		next_addrReg = addrReg;
		next_wdataReg = wdataReg;
		next_rdataReg = rdataReg;
		next_pending = pending;
		next_halted = halted;
		if (wrAccess && (state == ST_IDLE) && !pending)
		begin
			if (paddr == OFS_ADDR)
				next_addrReg = pwdata[13:0];
			if (paddr == OFS_WDATA)
				next_wdataReg = pwdata[7:0];
			if (wrCtrl)
				next_cycType = pwdata[CTRL_TYPE_LSB +: 2];
			if (wrCtrl && pwdata[CTRL_START_BIT] && !halted)
				next_pending = 1'b1;
		end
		if (cycleDone)
		begin
			next_pending = 1'b0;
			if (cycType != CYC_WRITE)
				next_rdataReg = ~data_lines_n_in;
		end
		if (wrCtrl && pwdata[CTRL_HALT_BIT] && (state == ST_IDLE))
			next_halted = 1'b1;
		if (wake)
			next_halted = 1'b0;
		if (master_reset)
			next_pending = 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			cycType <= TYPE_RESET;
			addrReg <= ADDR_RESET;
			wdataReg <= DATA_RESET;
			rdataReg <= DATA_RESET;
			pending <= 1'b0;
			halted <= 1'b0;
		end
		else
		begin
			cycType <= next_cycType;
			addrReg <= next_addrReg;
			wdataReg <= next_wdataReg;
			rdataReg <= next_rdataReg;
			pending <= next_pending;
			halted <= next_halted;
		end
	end

	// ==========================================================
	// cycle state machine
	bcb_state_t next_state;
	logic [7:0] winCount;
	logic [7:0] next_winCount;
	logic goOn;

	// T1 and T2 each last one phase period; the ready window is timed
	// in system clocks from the end of T2
	always_comb
	begin
		goOn = !ready_n && steppingHold_n;
		next_state = state;
		next_winCount = 8'h00;
		unique case (state)
			ST_IDLE:
				if (pending && tick)
					next_state = ST_T1;
			ST_T1:
				if (tick)
					next_state = ST_T2;
			ST_T2:
				if (tick)
					next_state = ST_WIN;
			ST_WIN:
			begin
				next_winCount = winCount + 8'h01;
				if (winCount == 8'(WIN_CYC - 1))
					next_state = goOn ? ST_T3 : ST_WAIT;
			end
			ST_WAIT:
				if (tick && goOn)
					next_state = ST_T3;
			ST_T3:
				if (tick)
					next_state = ST_IDLE;
		endcase
		if (master_reset)
			next_state = ST_IDLE;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			winCount <= 8'h00;
		end
		else
		begin
			state <= next_state;
			winCount <= next_winCount;
		end
	end

	// ==========================================================
	// bus pin drivers
	logic next_t2_n;
	logic next_t3_n;
	logic next_ext_n;
	logic next_cc0_n;
	logic next_cc1;
	logic [7:0] next_low_n;
	logic [5:0] next_page_n;
	logic [7:0] next_data_n;
	logic next_data_oe;
	logic next_wait_n;
	logic nextBusy;
	logic nextExt;

	// pins are registered from the next state so they change together
	always_comb
	begin
		nextBusy = (next_state != ST_IDLE);
		nextExt = (next_state == ST_WIN) || (next_state == ST_WAIT) ||
			(next_state == ST_T3);
		next_t2_n = (next_state != ST_T2);
		next_t3_n = (next_state != ST_T3);
		next_ext_n = !nextExt;
		next_cc0_n = 1'b1;
		next_cc1 = 1'b0;
		if (next_state == ST_T2)
		begin
			next_cc0_n = !cycType[0];
			next_cc1 = cycType[1];
		end
		next_low_n = 8'hff;
		next_page_n = 6'h3f;
		if (nextBusy)
		begin
			next_low_n = ~addrReg[ADDR_LOW_LSB +: 8];
			next_page_n = ~addrReg[ADDR_PAGE_LSB +: 6];
		end
		next_data_oe = nextExt && (cycType == CYC_WRITE);
		next_data_n = next_data_oe ? ~wdataReg : 8'hff;
		next_wait_n = !((next_state == ST_WAIT) && ready_n);
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			high_address_phase_n <= 1'b1;
			third_phase_n <= 1'b1;
			extThirdPhase_n <= 1'b1;
			cycle_type_bit0_n <= 1'b1;
			cycle_type_bit1 <= 1'b0;
			low_address_lines_n <= 8'hff;
			page_address_lines_n <= 6'h3f;
			data_lines_n_out <= 8'hff;
			data_lines_n_oe <= 1'b0;
			waitIndicator_n <= 1'b1;
		end
		else
		begin
			high_address_phase_n <= next_t2_n;
			third_phase_n <= next_t3_n;
			extThirdPhase_n <= next_ext_n;
			cycle_type_bit0_n <= next_cc0_n;
			cycle_type_bit1 <= next_cc1;
			low_address_lines_n <= next_low_n;
			page_address_lines_n <= next_page_n;
			data_lines_n_out <= next_data_n;
			data_lines_n_oe <= next_data_oe;
			waitIndicator_n <= next_wait_n;
		end
	end
	assign haltedIndicator_n = !halted;

	// ==========================================================
	// apb read data
	logic [31:0] next_prdata;
	logic [31:0] statusWord;
	// read data is captured in the setup cycle and stands for the access
	always_comb
	begin
		statusWord = 32'h00000000;
		statusWord[ST_BUSY_BIT] = (state != ST_IDLE) || pending;
		statusWord[ST_WAIT_BIT] = (state == ST_WAIT);
		statusWord[ST_HALT_BIT] = halted;
		statusWord[ST_L0_BIT] = !level_zero_request_n;
		statusWord[ST_SUB_BIT] = !substitute_n;
		statusWord[ST_HOLD_BIT] = !steppingHold_n;
		statusWord[ST_INT_LSB +: 7] = ~interrupt_request_lines_n;
		next_prdata = prdata;
		if (rdSetup)
		begin
			next_prdata = 32'h00000000;
			unique case (paddr)
				OFS_CTRL:
				begin
					next_prdata[CTRL_START_BIT] = pending;
					next_prdata[CTRL_HALT_BIT] = halted;
					next_prdata[CTRL_TYPE_LSB +: 2] = cycType;
				end
				OFS_ADDR:
					next_prdata[13:0] = addrReg;
				OFS_WDATA:
					next_prdata[7:0] = wdataReg;
				OFS_STATUS:
					next_prdata = statusWord;
				OFS_RDATA:
					next_prdata[7:0] = rdataReg;
				default:
					next_prdata = 32'h00000000;
			endcase
		end
	end
	always_ff @(posedge clock)
	begin
		if (reset)
			prdata <= 32'h00000000;
		else
			prdata <= next_prdata;
	end
endmodule

// file: sim/bcb_engine_sva.sv
// concurrent checks on the backplane cycle engine pins
`timescale 1ns/1ps
module bcb_engine_sva
	import bcb_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic reset, // sync reset
	input wire logic high_address_phase_n, // T2 timing
	input wire logic third_phase_n, // T3 timing
	input wire logic extThirdPhase_n, // extended phase
	input wire logic cycle_type_bit0_n, // code bit 0
	input wire logic cycle_type_bit1, // code bit 1
	input wire logic [7:0] data_lines_n_out, // driven data
	input wire logic data_lines_n_oe, // data enable
	input wire logic ready_n, // wait request
	input wire logic steppingHold_n, // console hold
	input wire logic restart_n, // restart line
	input wire logic [7:1] interrupt_request_lines_n, // levels
	input wire logic master_reset, // master reset
	input wire logic level_zero_request_n, // level-zero flag
	input wire logic waitIndicator_n, // wait lamp
	input wire logic haltedIndicator_n // halt lamp
);
	// ======
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	property p_code;
		high_address_phase_n |-> cycle_type_bit0_n && !cycle_type_bit1;
	endproperty
	a_code: assert property (p_code)
		else $error("cycle code shown outside T2");
	// 25 clocks is the 500 ns window at 50 MHz
	property p_ext;
		$rose(high_address_phase_n) |-> ##[0:25] !extThirdPhase_n;
	endproperty
	a_ext: assert property (p_ext)
		else $error("extended phase late after T2");
	property p_cover;
		!third_phase_n |-> !extThirdPhase_n;
	endproperty
	a_cover: assert property (p_cover)
		else $error("extended phase gap in T3");
	// pins switch with the state, so the deciding sample is one clock back
	property p_order;
		$fell(third_phase_n) |->
			!$past(ready_n) && $past(steppingHold_n);
	endproperty
	a_order: assert property (p_order)
		else $error("T3 entered while wait asked");
	property p_lamp;
		$fell(waitIndicator_n) |-> $past(ready_n) && third_phase_n;
	endproperty
	a_lamp: assert property (p_lamp)
		else $error("wait lamp without wait request");
	property p_wdata;
		data_lines_n_oe && $past(data_lines_n_oe) |->
			$stable(data_lines_n_out) && !extThirdPhase_n;
	endproperty
	a_wdata: assert property (p_wdata)
		else $error("write data moved in data phase");
	property p_halt;
		!haltedIndicator_n && !master_reset && !$past(master_reset)
			&& &interrupt_request_lines_n
			&& &$past(interrupt_request_lines_n)
			&& restart_n && level_zero_request_n |=> !haltedIndicator_n;
	endproperty
	a_halt: assert property (p_halt)
		else $error("halt left without wake");
	property p_restart;
		!restart_n |-> ##[1:2] !level_zero_request_n;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart did not raise level zero");
endmodule

bind bcb_bus_engine bcb_engine_sva u_bcb_engine_sva (.clock, .reset,
	.high_address_phase_n, .third_phase_n, .extThirdPhase_n,
	.cycle_type_bit0_n, .cycle_type_bit1, .data_lines_n_out,
	.data_lines_n_oe, .ready_n, .steppingHold_n, .restart_n,
	.interrupt_request_lines_n, .master_reset, .level_zero_request_n,
	.waitIndicator_n, .haltedIndicator_n);

// file: sim/bcb_card_model.sv
// memory or interface card answering processor bus cycles
`timescale 1ns/1ps
module bcb_card_model
(
	input wire logic clock, // system clock
	input wire logic reset, // sync reset
	input wire logic extThirdPhase_n, // data phase
	input wire logic data_lines_n_oe, // processor drives data
	input wire logic substitute_n, // low silences the card
	input wire logic [7:0] readByte, // value returned
	input wire logic [5:0] latency, // clocks before release
	output logic ready_n, // wait request
	output logic [7:0] dataOut_n, // data toward processor
	output logic dataOe // high while driving
);
	logic [5:0] count;
	logic [7:0] idle;
	// ======
	// data goes out first, wait request drops latency+1 clocks later
	always_ff @(posedge clock)
	begin
		idle <= reset ? 8'h5a : idle + 8'h35;
		if (reset || extThirdPhase_n)
		begin
			count <= 6'h00;
			ready_n <= 1'b1;
			dataOe <= 1'b0;
		end
		else
		begin
			count <= (count == 6'h3f) ? count : count + 6'h01;
			dataOe <= !data_lines_n_oe && substitute_n;
			ready_n <= !(count > latency);
		end
	end
	// released lines show a moving pattern, never the last value
	assign dataOut_n = dataOe ? ~readByte : idle;
endmodule

// file: sim/tb_top.sv
// self-checking bench for the backplane cycle engine
`timescale 1ns/1ps
module tb_top;
	import bcb_pkg::*;
	logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, err, sawWait, sawT3;
	logic [7:0] paddr = 8'h00, data_lines_n_in, dataOut_n, readByte = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic high_address_phase_n, third_phase_n, extThirdPhase_n;
	logic cycle_type_bit0_n, cycle_type_bit1, data_lines_n_oe, ready_n;
	logic [7:0] low_address_lines_n, data_lines_n_out, seenData;
	logic [5:0] page_address_lines_n, latency = 6'h00;
	logic steppingHold_n = 1'b1, restart_n = 1'b1, substitute_n = 1'b1;
	logic [7:1] irq = 7'h7f;
	logic master_reset = 1'b0, level_zero_request_n;
	logic waitIndicator_n, haltedIndicator_n;
	logic [1:0] seenType;
	logic [13:0] seenAddr;
	int fail_count = 0, checked = 0, cycles = 0, mHalt = 0, mL0 = 0;
	localparam int PHASE_CYC = 4;
	logic phase2Clock, sync_n, p2Was = 1'b0;
	int p2Rise = 0, p2Period = 0, syncRun = 0, syncLow = 0;

	always #10 clock = ~clock;
	assign data_lines_n_in = data_lines_n_oe ? data_lines_n_out : dataOut_n;

	bcb_bus_engine #(.PHASE_DIV(PHASE_CYC), .WIN_CYC(8)) u_bcb_bus_engine (
		.clock,
		.reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .phase2Clock, .sync_n, .high_address_phase_n,
		.third_phase_n, .extThirdPhase_n, .cycle_type_bit0_n,
		.cycle_type_bit1, .low_address_lines_n, .page_address_lines_n,
		.data_lines_n_in, .data_lines_n_out, .data_lines_n_oe, .ready_n,
		.steppingHold_n, .restart_n, .substitute_n,
		.interrupt_request_lines_n(irq), .master_reset,
		.level_zero_request_n, .waitIndicator_n, .haltedIndicator_n);
	bcb_card_model u_bcb_card_model (.clock, .reset, .extThirdPhase_n,
		.data_lines_n_oe, .substitute_n, .readByte, .latency, .ready_n,
		.dataOut_n, .dataOe());

	// ======
	// pin monitor, values taken before the edge updates land
	always @(posedge clock)
	begin
		cycles++;
		// phase period and sync low time, measured rise to rise
		if (phase2Clock === 1'b1 && p2Was !== 1'b1)
		begin
			p2Period = cycles - p2Rise;
			p2Rise = cycles;
			syncLow = syncRun;
			syncRun = 0;
		end
		p2Was = phase2Clock;
		if (sync_n === 1'b0)
			syncRun++;
		if (high_address_phase_n === 1'b0)
		begin
			seenType = {cycle_type_bit1, ~cycle_type_bit0_n};
			seenAddr = ~{page_address_lines_n, low_address_lines_n};
		end
		if (data_lines_n_oe === 1'b1)
			seenData = ~data_lines_n_out;
		if (waitIndicator_n === 1'b0)
			sawWait = 1'b1;
		if (third_phase_n === 1'b0)
			sawT3 = 1'b1;
		if (cycles == 30000)
		begin
			fail_count++;
			final_report;
		end
	end

	// ======
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer, held until pready is seen at an edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// status as the model expects it while no cycle runs
	function automatic logic [31:0] expSt();
		return {17'h0, ~irq, 2'h0, ~steppingHold_n, ~substitute_n,
			1'(mL0), 1'(mHalt), 2'h0};
	endfunction
	task automatic rdSt();
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", expSt(), rd);
	endtask
	task automatic waitIdle();
		do
			apb(1'b0, OFS_STATUS, 32'h0);
		while (rd[ST_BUSY_BIT] !== 1'b0);
	endtask
	// one full bus cycle of type t with a card of given latency
	task automatic runCycle(logic [1:0] t, logic [5:0] lat);
		logic [13:0] a;
		logic [7:0] w;
		a = 14'($urandom);
		w = 8'($urandom);
		latency <= lat;
		readByte <= 8'($urandom);
		sawWait = 1'b0;
		apb(1'b1, OFS_ADDR, 32'(a));
		apb(1'b1, OFS_WDATA, 32'(w));
		apb(1'b1, OFS_CTRL, (32'(t) << CTRL_TYPE_LSB) | 32'h1);
		waitIdle();
		chk("cycle type", 32'(t), 32'(seenType));
		chk("address", 32'(a), 32'(seenAddr));
		// an interface card decodes group and peripheral from the page lines
		if (t == CYC_IO)
		begin
			chk("io group", 32'(a[11:9]), 32'(seenAddr[11:9]));
			chk("io unit", 32'(a[13:9]), 32'(seenAddr[13:9]));
		end
		if (t == CYC_WRITE)
			chk("write data", 32'(w), 32'(seenData));
		else
		begin
			apb(1'b0, OFS_RDATA, 32'h0);
			chk("read data", 32'(readByte), rd);
		end
		chk("wait lamp", 32'(lat > 6'd8), 32'(sawWait));
	endtask
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ======
	initial
	begin
		void'($urandom(44));
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		irq <= 7'($urandom);
		substitute_n <= 1'b0;
		rdSt();
		substitute_n <= 1'b1;
		irq <= 7'h7f;
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", 32'h1, 32'(err));
		// every cycle type, prompt and slow card
		for (int i = 0; i < 8; i++)
			runCycle(2'(i), i[2] ? 6'd30 : 6'd0);
		// hold keeps the cycle out of T3 until released
		latency <= 6'd0;
		steppingHold_n <= 1'b0;
		sawT3 = 1'b0;
		apb(1'b1, OFS_CTRL, 32'h1);
		repeat (60) @(posedge clock);
		chk("T3 under hold", 32'h0, 32'(sawT3));
		steppingHold_n <= 1'b1;
		waitIdle();
		chk("T3 after hold", 32'h1, 32'(sawT3));
		// halt refuses a start, then interrupt and master reset wake
		apb(1'b1, OFS_CTRL, 32'h2);
		mHalt = 1;
		apb(1'b1, OFS_CTRL, 32'h1);
		rdSt();
		chk("halt lamp", 32'h0, 32'(haltedIndicator_n));
		irq <= 7'h7f ^ 7'(1 << ($urandom % 7));
		repeat (2) @(posedge clock);
		irq <= 7'h7f;
		mHalt = 0;
		rdSt();
		apb(1'b1, OFS_CTRL, 32'h2);
		master_reset <= 1'b1;
		@(posedge clock);
		master_reset <= 1'b0;
		rdSt();
		// one clock of restart raises level zero, ack lowers it
		restart_n <= 1'b0;
		@(posedge clock);
		restart_n <= 1'b1;
		mL0 = 1;
		rdSt();
		apb(1'b1, OFS_CTRL, 32'h4);
		mL0 = 0;
		rdSt();
		chk("phase period", 32'(PHASE_CYC), 32'(p2Period));
		chk("sync low", 32'(PHASE_CYC / 2), 32'(syncLow));
		final_report();
	end
endmodule
